// >>> core/acl_defines.vh
`ifndef ACL_DEFINES_VH
`define ACL_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACL_OFF_CTRL      8'h00
`define ACL_OFF_STATUS    8'h04
`define ACL_OFF_INT_STAT  8'h08
`define ACL_OFF_INT_MASK  8'h0C
`define ACL_OFF_OUT_LEFT  8'h10
`define ACL_OFF_OUT_RIGHT 8'h14
`define ACL_OFF_IN_LEFT   8'h18
`define ACL_OFF_IN_RIGHT  8'h1C

// ----------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------
`define ACL_CTRL_SHUTOFF  0
`define ACL_CTRL_RUN      1
`define ACL_CTRL_MODE_LO  2
`define ACL_CTRL_MODE_HI  3
`define ACL_CTRL_PRI_LO   4
`define ACL_CTRL_PRI_HI   5
`define ACL_CTRL_SEC_LO   6
`define ACL_CTRL_SEC_HI   7
`define ACL_CTRL_RESET    8'h01

// ----------------------------------------------------------------
// channel modes and codec kinds
// ----------------------------------------------------------------
`define ACL_MODE_2CH      2'h0
`define ACL_MODE_4CH      2'h1
`define ACL_MODE_6CH      2'h2
`define ACL_KIND_NONE     2'h0
`define ACL_KIND_AUDIO    2'h1
`define ACL_KIND_MODEM    2'h2
`define ACL_KIND_AUDMODEM 2'h3

// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define ACL_INT_FRAME     0
`define ACL_INT_WAKE      1
`define ACL_INT_TAKEN     2

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define ACL_SLOTS         4'hC
`define ACL_TAG_LAST      5'h0F
`define ACL_SLOT_LAST     5'h13
`define ACL_MSB           5'h13
`define ACL_TAG_FRAME     15
`define ACL_TAG_S3        12
`define ACL_TAG_S4        11
`define ACL_TAG_S6        9
`define ACL_TAG_S7        8
`define ACL_TAG_S8        7
`define ACL_TAG_S9        6
`define ACL_REQ_S3        11
`define ACL_REQ_S4        10
`define ACL_REQ_S6        8
`define ACL_REQ_S7        7
`define ACL_REQ_S8        6
`define ACL_REQ_S9        5
`define ACL_READY_BIT     15
`define ACL_RESP_OKAY     2'h0
`define ACL_RESP_SLVERR   2'h2

`endif

// >>> core/acl_sync2.v
`timescale 1ns/10ps
// two-flop synchroniser; the first stage feeds only the second
module acl_sync2 (
    input  wire aclk,
    input  wire aresetn,
    input  wire din,
    output reg  dout
);
    reg meta;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// >>> core/acl_link_ctrl.v
`timescale 1ns/10ps
module acl_link_ctrl (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        link_bit_clock,
    input  wire        serial_in_line_first,
    input  wire        serial_in_line_second,
    input  wire        board_codec_enable_n,
    output reg         serial_out_line,
    output reg         frame_sync,
    output reg         codec_reset_n,
    output reg         link_pull_enable,
    output reg         wake_request,
    output wire        irq
);
`include "acl_defines.vh"

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire bclk_s;
    wire sdin0_s;
    wire sdin1_s;
    wire board_en_n_s;

    acl_sync2 u_sync_bclk (.aclk(aclk), .aresetn(aresetn), .din(link_bit_clock), .dout(bclk_s));
    acl_sync2 u_sync_in0  (.aclk(aclk), .aresetn(aresetn), .din(serial_in_line_first), .dout(sdin0_s));
    acl_sync2 u_sync_in1  (.aclk(aclk), .aresetn(aresetn), .din(serial_in_line_second), .dout(sdin1_s));
    acl_sync2 u_sync_ben  (.aclk(aclk), .aresetn(aresetn), .din(board_codec_enable_n), .dout(board_en_n_s));

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg  [7:0]  ctrl;
    reg  [2:0]  int_stat;
    reg  [2:0]  int_mask;
    reg  [19:0] out_left;
    reg  [19:0] out_right;
    reg  [19:0] in_left;
    reg  [19:0] in_right;
    reg         pri_ready;
    reg         sec_ready;
    reg  [11:2] pri_req;
    reg  [11:2] sec_req;

    wire        shutoff  = ctrl[`ACL_CTRL_SHUTOFF];
    wire [1:0]  mode     = ctrl[`ACL_CTRL_MODE_HI:`ACL_CTRL_MODE_LO];
    wire [1:0]  pri_kind = ctrl[`ACL_CTRL_PRI_HI:`ACL_CTRL_PRI_LO];
    wire [1:0]  sec_kind = ctrl[`ACL_CTRL_SEC_HI:`ACL_CTRL_SEC_LO];

    // pairing check: a secondary needs an audio primary
    wire cfg_ok = (pri_kind != `ACL_KIND_NONE) &&
                  ((sec_kind == `ACL_KIND_NONE) || (pri_kind == `ACL_KIND_AUDIO));
    // second line used only when a secondary is declared
    wire sec_used = (sec_kind != `ACL_KIND_NONE);
    wire link_on  = !shutoff && ctrl[`ACL_CTRL_RUN] && cfg_ok;

    // ------------------------------------------------------------
    // bit clock edges
    // ------------------------------------------------------------
    reg  bclk_d;
    wire bclk_rise = bclk_s & ~bclk_d;
    wire bclk_fall = ~bclk_s & bclk_d;

    // ------------------------------------------------------------
    // frame position and output slots
    // ------------------------------------------------------------
    reg  [3:0]  slot;
    reg  [4:0]  pos;
    reg         send_pcm;
    reg  [19:0] lat_left;
    reg  [19:0] lat_right;
    reg  [19:0] sh0;
    reg  [19:0] sh1;
    reg         ev_frame;
    reg         ev_taken;
    reg         ev_wake;
    reg         sdin_any_d;

    wire [4:0]  slot_last = (slot == 4'h0) ? `ACL_TAG_LAST : `ACL_SLOT_LAST;
    wire        at_end    = (pos == slot_last);
    wire        frame_end = at_end && (slot == `ACL_SLOTS);
    wire [3:0]  next_slot = frame_end ? 4'h0 : (at_end ? slot + 4'h1 : slot);
    wire [4:0]  next_pos  = at_end ? 5'h00 : pos + 5'h01;

    // slot requests are active low; secondary needed in 4 and 6 channel modes
    wire pri_go = ~pri_req[`ACL_REQ_S3] & ~pri_req[`ACL_REQ_S4];
    wire sec4   = ~sec_req[`ACL_REQ_S7] & ~sec_req[`ACL_REQ_S8];
    wire sec6   = sec4 & ~sec_req[`ACL_REQ_S6] & ~sec_req[`ACL_REQ_S9];
    wire go     = pri_go && ((mode == `ACL_MODE_2CH) ? 1'b1 :
                             (mode == `ACL_MODE_4CH) ? sec4 : sec6);
    wire pcm_now = frame_end ? go : send_pcm;

    reg [15:0] tag;
    reg [19:0] word;
    always @* begin
        tag = 16'h0000;
        tag[`ACL_TAG_FRAME] = pcm_now;
        tag[`ACL_TAG_S3] = pcm_now;
        tag[`ACL_TAG_S4] = pcm_now;
        if (mode != `ACL_MODE_2CH) begin
            tag[`ACL_TAG_S7] = pcm_now;
            tag[`ACL_TAG_S8] = pcm_now;
        end
        if (mode == `ACL_MODE_6CH) begin
            tag[`ACL_TAG_S6] = pcm_now;
            tag[`ACL_TAG_S9] = pcm_now;
        end
        case (next_slot)
            4'h0: word = {tag, 4'h0};
            4'h3: word = tag[`ACL_TAG_S3] ? lat_left : 20'h00000;
            4'h4: word = tag[`ACL_TAG_S4] ? lat_right : 20'h00000;
            4'h6: word = tag[`ACL_TAG_S6] ? lat_left : 20'h00000;
            4'h7: word = tag[`ACL_TAG_S7] ? lat_left : 20'h00000;
            4'h8: word = tag[`ACL_TAG_S8] ? lat_right : 20'h00000;
            4'h9: word = tag[`ACL_TAG_S9] ? lat_right : 20'h00000;
            default: word = 20'h00000;
        endcase
    end

    wire [19:0] cap0 = {sh0[18:0], sdin0_s};
    wire [19:0] cap1 = {sh1[18:0], sdin1_s};

    always @(posedge aclk) begin
        if (!aresetn) begin
            bclk_d          <= 1'b0;
            slot            <= `ACL_SLOTS;
            pos             <= `ACL_SLOT_LAST;
            send_pcm        <= 1'b0;
            lat_left        <= 20'h00000;
            lat_right       <= 20'h00000;
            serial_out_line <= 1'b0;
            frame_sync      <= 1'b0;
            sh0             <= 20'h00000;
            sh1             <= 20'h00000;
            in_left         <= 20'h00000;
            in_right        <= 20'h00000;
            pri_ready       <= 1'b0;
            sec_ready       <= 1'b0;
            pri_req         <= 10'h3FF;
            sec_req         <= 10'h3FF;
            ev_frame        <= 1'b0;
            ev_taken        <= 1'b0;
        end else begin
            bclk_d   <= bclk_s;
            ev_frame <= 1'b0;
            ev_taken <= 1'b0;
            if (!link_on) begin
                // link idle: next rising edge opens a fresh frame
                slot            <= `ACL_SLOTS;
                pos             <= `ACL_SLOT_LAST;
                serial_out_line <= 1'b0;
                frame_sync      <= 1'b0;
                send_pcm        <= 1'b0;
            end else if (bclk_rise) begin
                slot            <= next_slot;
                pos             <= next_pos;
                serial_out_line <= word[`ACL_MSB - next_pos];
                // sync high through the tag slot
                frame_sync      <= (next_slot == 4'h0);
                if (frame_end) begin
                    // data released only once requests are in
                    send_pcm  <= go;
                    ev_frame  <= 1'b1;
                    ev_taken  <= go;
                    if (go) begin
                        lat_left  <= out_left;
                        lat_right <= out_right;
                    end
                end
            end else if (bclk_fall) begin
                // tag and request slots captured from both return lines, slots 3 and 4 from the first only
                sh0 <= cap0;
                sh1 <= cap1;
                if (at_end) begin
                    case (slot)
                        4'h0: begin
                            pri_ready <= cap0[`ACL_READY_BIT];
                            sec_ready <= sec_used & cap1[`ACL_READY_BIT];
                        end
                        4'h1: begin
                            pri_req <= cap0[11:2];
                            sec_req <= sec_used ? cap1[11:2] : 10'h3FF;
                        end
                        4'h3: in_left  <= cap0;
                        4'h4: in_right <= cap0;
                        default: sh0 <= cap0;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // wake, reset and pull control
    // ------------------------------------------------------------
    wire sdin_any = sdin0_s | (sec_used & sdin1_s);

    always @(posedge aclk) begin
        if (!aresetn) begin
            sdin_any_d       <= 1'b0;
            ev_wake          <= 1'b0;
            codec_reset_n    <= 1'b0;
            link_pull_enable <= 1'b1;
            wake_request     <= 1'b0;
        end else begin
            sdin_any_d       <= sdin_any;
            // rise on a return line while the link is off
            ev_wake          <= shutoff & sdin_any & ~sdin_any_d;
            // codec held in reset until software runs the link
            codec_reset_n    <= ctrl[`ACL_CTRL_RUN];
            link_pull_enable <= shutoff;
            wake_request     <= int_stat[`ACL_INT_WAKE];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    reg        aw_full;
    reg        w_full;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq           = |(int_stat & int_mask);

    wire do_wr = aw_full && w_full && !s_axi_bvalid;
    wire wr_ok = (aw_addr[7:5] == 3'h0) && (aw_addr[1:0] == 2'h0);
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [2:0]  ev_bits = {ev_taken, ev_wake, ev_frame};
    wire [2:0]  clr = (do_wr && aw_addr == `ACL_OFF_INT_STAT) ? (w_data[2:0] & wmask[2:0]) : 3'h0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ACL_RESP_OKAY;
            ctrl         <= `ACL_CTRL_RESET;
            int_mask     <= 3'h0;
            int_stat     <= 3'h0;
            out_left     <= 20'h00000;
            out_right    <= 20'h00000;
        end else begin
            if (s_axi_awvalid && !aw_full) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // new events win over a same-cycle clear
            int_stat <= (int_stat & ~clr) | ev_bits;
            if (do_wr) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
                case (aw_addr)
                    `ACL_OFF_CTRL:      ctrl      <= (ctrl & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0]);
                    `ACL_OFF_INT_MASK:  int_mask  <= (int_mask & ~wmask[2:0]) | (w_data[2:0] & wmask[2:0]);
                    `ACL_OFF_OUT_LEFT:  out_left  <= (out_left & ~wmask[19:0]) | (w_data[19:0] & wmask[19:0]);
                    `ACL_OFF_OUT_RIGHT: out_right <= (out_right & ~wmask[19:0]) | (w_data[19:0] & wmask[19:0]);
                    default:            ctrl      <= ctrl;
                endcase
            end
        end
    end

    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_ok  = 1'b1;
        rd_val = 32'h00000000;
        case (s_axi_araddr)
            `ACL_OFF_CTRL:      rd_val = {24'h000000, ctrl};
            // board enable level shown to firmware
            `ACL_OFF_STATUS:    rd_val = {27'h0000000, link_on, sec_ready, pri_ready, board_en_n_s, cfg_ok};
            `ACL_OFF_INT_STAT:  rd_val = {29'h00000000, int_stat};
            `ACL_OFF_INT_MASK:  rd_val = {29'h00000000, int_mask};
            `ACL_OFF_OUT_LEFT:  rd_val = {12'h000, out_left};
            `ACL_OFF_OUT_RIGHT: rd_val = {12'h000, out_right};
            `ACL_OFF_IN_LEFT:   rd_val = {12'h000, in_left};
            `ACL_OFF_IN_RIGHT:  rd_val = {12'h000, in_right};
            default:            rd_ok  = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `ACL_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `ACL_RESP_OKAY : `ACL_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> dv/acl_link_ctrl_asserts.sv
`timescale 1ns/10ps
`include "acl_defines.vh"
module acl_link_ctrl_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        serial_out_line,
    input wire        frame_sync,
    input wire        codec_reset_n,
    input wire        link_pull_enable,
    input wire        wake_request,
    input wire        irq
);
    // ----------------------------------------------------------------
    // frame timing: one bit is 8 aclk cycles, a frame 256 bits
    // ----------------------------------------------------------------
    localparam int SYNC_MIN = 126;
    localparam int SYNC_MAX = 130;
    localparam int FRM_MIN  = 2044;
    localparam int FRM_MAX  = 2052;
    reg [11:0] sync_len;
    reg [11:0] frame_len;
    reg        armed;
    reg        sync_q;
    // armed at a frame start; the first sync rise after idle is not judged
    always @(posedge aclk) begin
        if (!aresetn || !frame_sync)
            sync_len <= 12'h000;
        else
            sync_len <= sync_len + 12'h001;
        if (!aresetn || link_pull_enable || !codec_reset_n) begin
            armed     <= 1'h0;
            frame_len <= 12'h000;
        end else if (frame_sync && !sync_q) begin
            armed     <= 1'h1;
            frame_len <= 12'h001;
        end else if (frame_len != 12'hFFF)
            frame_len <= frame_len + 12'h001;
        sync_q <= frame_sync;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_sync_width: assert property ($fell(frame_sync) |-> sync_len inside {[SYNC_MIN:SYNC_MAX]})
        else $error("frame sync width out of range");
    chk_frame_period: assert property ($rose(frame_sync) && armed |-> frame_len inside {[FRM_MIN:FRM_MAX]})
        else $error("frame period out of range");
    chk_pulls_idle: assert property (link_pull_enable [*3] |-> !frame_sync && !serial_out_line)
        else $error("link active while pulls enabled");
    chk_reset_idle: assert property (!codec_reset_n [*3] |-> !frame_sync && !serial_out_line)
        else $error("link active while codecs in reset");
    chk_wake_shutoff: assert property ($rose(wake_request) |-> $past(link_pull_enable))
        else $error("wake raised with link on");
    chk_wake_irq: assert property ($rose(wake_request) |-> irq)
        else $error("wake without interrupt");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    cover property ($rose(frame_sync));
    cover property ($rose(wake_request));
    cover property (s_axi_bvalid && s_axi_bresp == `ACL_RESP_SLVERR);
endmodule
bind acl_link_ctrl acl_link_ctrl_asserts i_acl_link_ctrl_asserts (.*);

// >>> dv/acl_codec_model.sv
`timescale 1ns/10ps
module acl_codec_model (
    input  wire        codec_reset_n,
    input  wire        frame_sync,
    input  wire        ring,
    input  wire [19:0] req_first,
    input  wire [19:0] req_second,
    input  wire [19:0] left_in,
    input  wire [19:0] right_in,
    output reg         link_bit_clock,
    output wire        serial_in_line_first,
    output wire        serial_in_line_second
);
    integer bitpos = 255;
    reg     sync_seen = 1'h0;
    reg     bit_first = 1'h0;
    reg     bit_second = 1'h0;
    function automatic reg bit_of(input integer p, input [19:0] s1, input [19:0] s3, input [19:0] s4);
        integer slot;
        integer b;
        begin
            slot = (p < 16) ? 0 : (p - 16) / 20 + 1;
            b = (p < 16) ? 15 - p : 19 - (p - 16) % 20;
            case (slot)
                0: bit_of = (b == 15) || (b == 14) || (b == 12) || (b == 11);
                1: bit_of = s1[b];
                3: bit_of = s3[b];
                4: bit_of = s4[b];
                default: bit_of = 1'h0;
            endcase
        end
    endfunction
    // bit clock from the primary; stands low while held in reset
    initial begin
        link_bit_clock = 1'h0;
        #7;
        forever begin
            #160;
            link_bit_clock = codec_reset_n ? ~link_bit_clock : 1'h0;
        end
    end
    // launch on the rise; sync settles late in the bit
    always @(posedge link_bit_clock) begin
        bitpos = (frame_sync && !sync_seen) ? 1 : (bitpos + 1) % 256;
        sync_seen = frame_sync;
        bit_first <= bit_of(bitpos, req_first, left_in, right_in);
        bit_second <= bit_of(bitpos, req_second, 20'h00000, 20'h00000);
    end
    // ring raises the first line; released lines fall to their pull-down
    assign serial_in_line_first  = ring | (codec_reset_n & bit_first);
    assign serial_in_line_second = codec_reset_n & bit_second;
endmodule

// >>> dv/acl_link_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "acl_defines.vh"
module acl_link_ctrl_tb_top;
    reg         aclk = 1'h0;
    reg         aresetn = 1'h0;
    reg  [7:0]  s_axi_awaddr = 8'h00;
    reg         s_axi_awvalid = 1'h0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    reg         s_axi_wvalid = 1'h0;
    reg         s_axi_bready = 1'h0;
    reg  [7:0]  s_axi_araddr = 8'h00;
    reg         s_axi_arvalid = 1'h0;
    reg         s_axi_rready = 1'h0;
    reg         board_codec_enable_n = 1'h0;
    reg         ring = 1'h0;
    reg  [19:0] req_first = 20'hFFFFF;
    reg  [19:0] req_second = 20'hFFFFF;
    reg  [19:0] left_in = 20'h5A5A5;
    reg  [19:0] right_in = 20'hA5A5A;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        link_bit_clock, serial_in_line_first, serial_in_line_second, serial_out_line;
    wire        frame_sync, codec_reset_n, link_pull_enable, wake_request;
    integer     mismatches = 0;
    integer     n_compared = 0;
    integer     cycles = 0;
    integer     frames = 0;
    integer     cnt = 300;
    integer     p, s;
    reg         sync_q = 1'h0;
    reg [255:0] frm;
    reg [255:0] last_frame;
    acl_link_ctrl i_acl_link_ctrl (.*);
    acl_codec_model i_acl_codec_model (.*);
    always #20 aclk = ~aclk;
    // ----------------------------------------------------------------
    // watchdog and frame capture
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            mismatches = mismatches + 1;
            tally_and_finish;
        end
    end
    // sampled on the next rise: the controller launches late in the bit
    always @(posedge link_bit_clock) begin
        if (frame_sync && !sync_q)
            cnt = 0;
        if (cnt < 256) begin
            frm = {frm[254:0], serial_out_line};
            cnt = cnt + 1;
            if (cnt == 256) begin
                last_frame = frm;
                frames = frames + 1;
            end
        end
        sync_q = frame_sync;
    end
    task check(input [31:0] seen, input [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // handshakes judged on values sampled at each rising edge
    task axi_write(input [7:0] a, input [31:0] d, input [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        while (!s_axi_bvalid) begin
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            @(posedge aclk);
        end
        s_axi_bready <= 1'h0;
        check(s_axi_bresp, er);
    endtask
    task axi_read(input [7:0] a, input [31:0] m, input [31:0] ed, input [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        while (!s_axi_rvalid) begin
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            @(posedge aclk);
        end
        s_axi_rready <= 1'h0;
        check(s_axi_rdata & m, ed);
        check(s_axi_rresp, er);
    endtask
    task wait_frames(input integer n);
        s = frames + n;
        while (frames < s) @(posedge aclk);
    endtask
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(`ACL_OFF_CTRL, 32'hFF, `ACL_CTRL_RESET, `ACL_RESP_OKAY);
        check(link_pull_enable, 1'h1);
        check(codec_reset_n, 1'h0);
        axi_read(`ACL_OFF_STATUS, 32'h2, 32'h0, `ACL_RESP_OKAY);
        board_codec_enable_n <= 1'h1;
        repeat (4) @(posedge aclk);
        axi_read(`ACL_OFF_STATUS, 32'h2, 32'h2, `ACL_RESP_OKAY);
        axi_read(8'h20, 32'hFFFFFFFF, 32'h0, `ACL_RESP_SLVERR);
        axi_write(8'h22, 32'hFFFFFFFF, `ACL_RESP_SLVERR);
        $display("test reset done");
        for (p = 0; p < 16; p = p + 1) begin
            axi_write(`ACL_OFF_CTRL, {24'h0, p[3:0], 4'h1}, `ACL_RESP_OKAY);
            axi_read(`ACL_OFF_STATUS, 32'h1, {31'h0, p[1:0] != 2'h0 && (p[3:2] == 2'h0 || p[1:0] == `ACL_KIND_AUDIO)},
                `ACL_RESP_OKAY);
        end
        axi_write(`ACL_OFF_CTRL, 32'hF2, `ACL_RESP_OKAY);
        s = frames;
        repeat (2200) @(posedge aclk);
        check(frames - s, 32'h0);
        $display("test config done");
        axi_write(`ACL_OFF_OUT_LEFT, 32'h12345, `ACL_RESP_OKAY);
        axi_write(`ACL_OFF_OUT_RIGHT, 32'hABCDE, `ACL_RESP_OKAY);
        axi_write(`ACL_OFF_INT_MASK, 32'h7, `ACL_RESP_OKAY);
        req_first <= 20'hFF3FF;
        axi_write(`ACL_OFF_CTRL, 32'h12, `ACL_RESP_OKAY);
        wait_frames(3);
        check(link_pull_enable, 1'h0);
        check(codec_reset_n, 1'h1);
        check(last_frame[255:251], 5'h13);
        check(last_frame[199 -: 20], 20'h12345);
        check(last_frame[179 -: 20], 20'hABCDE);
        axi_read(`ACL_OFF_IN_LEFT, 32'hFFFFF, 32'h5A5A5, `ACL_RESP_OKAY);
        axi_read(`ACL_OFF_IN_RIGHT, 32'hFFFFF, 32'hA5A5A, `ACL_RESP_OKAY);
        axi_read(`ACL_OFF_STATUS, 32'h14, 32'h14, `ACL_RESP_OKAY);
        axi_read(`ACL_OFF_INT_STAT, 32'h5, 32'h5, `ACL_RESP_OKAY);
        check(irq, 1'h1);
        axi_write(`ACL_OFF_INT_MASK, 32'h0, `ACL_RESP_OKAY);
        check(irq, 1'h0);
        axi_write(`ACL_OFF_INT_MASK, 32'h7, `ACL_RESP_OKAY);
        $display("test two channel done");
        axi_write(`ACL_OFF_CTRL, 32'h56, `ACL_RESP_OKAY);
        wait_frames(3);
        check(last_frame[199 -: 20], 20'h0);
        check(last_frame[255:252], 4'h0);
        axi_write(`ACL_OFF_INT_STAT, 32'h7, `ACL_RESP_OKAY);
        wait_frames(1);
        axi_read(`ACL_OFF_INT_STAT, 32'h4, 32'h0, `ACL_RESP_OKAY);
        req_second <= 20'hFFF3F;
        wait_frames(3);
        check(last_frame[199 -: 20], 20'h12345);
        check(last_frame[119 -: 20], 20'h12345);
        axi_write(`ACL_OFF_CTRL, 32'h5A, `ACL_RESP_OKAY);
        wait_frames(2);
        check(last_frame[199 -: 20], 20'h0);
        req_second <= 20'hFFE1F;
        wait_frames(3);
        check(last_frame[139 -: 20], 20'h12345);
        check(last_frame[79 -: 20], 20'hABCDE);
        $display("test multi channel done");
        @(negedge frame_sync);
        axi_write(`ACL_OFF_CTRL, 32'h01, `ACL_RESP_OKAY);
        axi_write(`ACL_OFF_INT_STAT, 32'h7, `ACL_RESP_OKAY);
        ring <= 1'h1;
        repeat (8) @(posedge aclk);
        check(wake_request, 1'h1);
        check(irq, 1'h1);
        ring <= 1'h0;
        axi_write(`ACL_OFF_INT_STAT, 32'h2, `ACL_RESP_OKAY);
        axi_read(`ACL_OFF_INT_STAT, 32'h2, 32'h0, `ACL_RESP_OKAY);
        check(wake_request, 1'h0);
        $display("test wake done");
        tally_and_finish;
    end
endmodule
